// ==== logic/sleep_pkg.sv ====
`default_nettype none
package sleep_pkg;
  // Register word indices; byte address is four times the index
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_SLEEP = 10'h033;
  localparam logic [IDX_W-1:0] IDX_MCU = 10'h035;
  localparam logic [IDX_W-1:0] IDX_GATE = 10'h064;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h070;
  // Sleep control fields
  localparam int SC_ARM = 0;
  localparam int SC_MODE = 1;
  localparam int MODE_W = 3;
  localparam int SC_W = 4;
  // MCU control fields
  localparam int MC_VUNL = 0;
  localparam int MC_VSEL = 1;
  localparam int MC_PUD = 4;
  localparam int MC_UNLOCK = 5;
  localparam int MC_OFF = 6;
  // Reset values and masks
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] MC_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] GATE_MASK = 8'hEF;
  localparam int GATE_ADC = 0;
  // Timing in clock cycles
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] STANDBY_WAKE_CYC = 16'h0006;
  localparam logic [CNT_W-1:0] HALT_CYC = 16'h0004;
  localparam logic [CNT_W-1:0] QUICK_WAKE_CYC = 16'h0001;
  localparam int SEQ_W = 3;
  localparam logic [SEQ_W-1:0] UNLOCK_CYC = 3'h4;
  localparam logic [SEQ_W-1:0] OFF_DELAY_CYC = 3'h3;
  localparam logic [SEQ_W-1:0] OFF_HOLD_CYC = 3'h3;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000, MODE_NOISE = 3'b001, MODE_PDOWN = 3'b010,
    MODE_PSAVE = 3'b011, MODE_RES4 = 3'b100, MODE_RES5 = 3'b101,
    MODE_STANDBY = 3'b110, MODE_EXT_STANDBY = 3'b111
  } sleep_mode_e;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00, ST_SLEEP = 2'b01, ST_WAKE = 2'b10, ST_HALT = 2'b11
  } power_state_e;
  typedef struct packed {
    logic cpu;
    logic io;
    logic adc;
    logic async_timer;
    logic main_osc;
  } clk_en_s;
  typedef struct packed {
    logic adc_on;
    logic adc_extended;
    logic comp_on;
    logic vref_on;
    logic monitor_on;
    logic wdt_run;
  } analog_ctl_s;
endpackage
`default_nettype wire

// ==== logic/wake_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module wake_timer #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic done_o
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire busy = cnt_reg != '0;

  // Load wins over the running count
  assign cnt_next = load_i ? load_val_i : (busy ? cnt_reg - W'(1) : cnt_reg);
  assign done_o = ce_i && cnt_reg == W'(1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// ==== logic/monitor_off_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module monitor_off_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic off_i,
  input wire logic unlock_i,
  output logic off_bit_o,
  output logic window_o,
  output logic active_o
);
  localparam logic [2:0] ONE = 3'h1;
  localparam logic [2:0] OFF_DELAY_CYC = sleep_pkg::OFF_DELAY_CYC;
  localparam logic [2:0] OFF_HOLD_CYC = sleep_pkg::OFF_HOLD_CYC;
  localparam logic [2:0] LAST = 3'(OFF_DELAY_CYC + OFF_HOLD_CYC);
  logic [2:0] win_reg;
  logic [2:0] win_next;
  logic [2:0] age_reg;
  logic [2:0] age_next;
  wire open_cmd = wr_i && off_i && unlock_i;
  wire set_cmd = wr_i && off_i && !unlock_i && win_reg != '0;
  wire clr_cmd = wr_i && !off_i;

  assign win_next = open_cmd ? sleep_pkg::UNLOCK_CYC :
                    (win_reg != '0 ? win_reg - ONE : win_reg);
  assign age_next = set_cmd ? ONE :
                    (clr_cmd || age_reg == LAST) ? '0 :
                    (age_reg != '0 ? age_reg + ONE : age_reg);
  assign off_bit_o = age_reg != '0;
  assign window_o = win_reg != '0;
  assign active_o = age_reg > OFF_DELAY_CYC;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_reg <= '0;
      age_reg <= '0;
    end else if (ce_i) begin
      win_reg <= win_next;
      age_reg <= age_next;
    end
  end

  property p_off_timing;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    $rose(off_bit_o) |-> !active_o [*3] ##1 active_o [*3] ##1 !off_bit_o;
  endproperty
  a_off_timing: assert property (p_off_timing)
    else $error("turn-off bit timing wrong");

  property p_unlock;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
    $rose(off_bit_o) |-> $past(window_o);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("turn-off bit set without unlock window");
endmodule
`default_nettype wire

// ==== logic/sleep_mode_power_control.sv ====
// Notes on behaviour
// - mode 110 with crystal enters standby
// - standby wakes after six cycles
// - mode 111 with crystal enters extended standby
// - extended standby wakes after six cycles
// - gate bit stops and freezes a peripheral
// - clearing gate bit resumes peripheral unchanged
// - gating matters only in active, idle and noise reduction
// - converter stays on; re-enable forces extended conversion
// - comparator off in deep sleep; reference stays on while requested
// - fused supply monitor stays on in sleep unless turn-off active at deep sleep entry
// - reference on while monitor, comparator, converter need
// - enabled watchdog keeps running in sleep
// - input buffers off in deep sleep except wake
// - debug fuse keeps main clock in sleep
// - upper four sleep control bits read zero
// - mode field encodes six modes, two reserved
// - sleep only when arm bit is set
// - turn-off bit needs unlock then write within four
// - turn-off active after three, cleared three later
// - monitor re-enabled on wake before execution
// - core halted four cycles beyond start-up
// - power-down stops all clocks and oscillator
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_power_control #(
  parameter int NPIN = 23,
  parameter logic [15:0] START_UP_CYC = 16'h0010
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_instr_i,
  input wire logic wake_i,
  input wire logic ext_crystal_i,
  input wire logic debug_enable_fuse_i,
  input wire logic monitor_fuse_en_i,
  input wire logic adc_enable_i,
  input wire logic adc_conv_start_i,
  input wire logic comp_enable_i,
  input wire logic comp_use_ref_i,
  input wire logic wdt_enable_i,
  input wire logic [NPIN-1:0] wake_pin_need_i,
  output sleep_pkg::clk_en_s clk_en_o,
  output logic [7:0] periph_clk_en_o,
  output logic [7:0] periph_access_o,
  output sleep_pkg::analog_ctl_s analog_o,
  output logic [NPIN-1:0] input_buf_en_o,
  output logic pullup_global_off_o,
  output logic vector_table_select_o
);
  typedef sleep_pkg::sleep_mode_e mode_t;

  function automatic sleep_pkg::sleep_mode_e effective_mode(
    input logic [2:0] m,
    input logic xtal
  );
    sleep_pkg::sleep_mode_e r;
    r = sleep_pkg::sleep_mode_e'(m);
    if (r == sleep_pkg::MODE_STANDBY && !xtal) begin
      r = sleep_pkg::MODE_PDOWN;
    end else if (r == sleep_pkg::MODE_EXT_STANDBY && !xtal) begin
      r = sleep_pkg::MODE_PSAVE;
    end
    return r;
  endfunction

  // Modes in which both the I/O and converter clocks stop
  function automatic logic is_deep(input sleep_pkg::sleep_mode_e m);
    return m != sleep_pkg::MODE_IDLE && m != sleep_pkg::MODE_NOISE;
  endfunction

  function automatic logic [15:0] wake_cycles(
    input sleep_pkg::sleep_mode_e m
  );
    logic [15:0] r;
    r = sleep_pkg::QUICK_WAKE_CYC;
    case (m)
      sleep_pkg::MODE_STANDBY, sleep_pkg::MODE_EXT_STANDBY: begin
        r = sleep_pkg::STANDBY_WAKE_CYC;
      end
      sleep_pkg::MODE_PDOWN, sleep_pkg::MODE_PSAVE: begin
        r = START_UP_CYC;
      end
      default: begin
        r = sleep_pkg::QUICK_WAKE_CYC;
      end
    endcase
    return r;
  endfunction

  // Register file
  logic [7:0] sc_reg;
  logic [7:0] mc_reg;
  logic [7:0] gate_reg;
  logic [31:0] prdata_reg;
  wire [9:0] idx = paddr_i[11:sleep_pkg::IDX_LSB];
  wire hit_sc = idx == sleep_pkg::IDX_SLEEP;
  wire hit_mc = idx == sleep_pkg::IDX_MCU;
  wire hit_gate = idx == sleep_pkg::IDX_GATE;
  wire hit_st = idx == sleep_pkg::IDX_STATUS;
  wire hit_any = hit_sc || hit_mc || hit_gate || hit_st;
  wire setup_ph = psel_i && !penable_i;
  wire access_ph = psel_i && penable_i && ce_i;
  wire wr_ok = access_ph && pwrite_i && hit_any;
  wire wr_sc = wr_ok && hit_sc;
  wire wr_mc = wr_ok && hit_mc;
  wire wr_gate = wr_ok && hit_gate;
  wire [7:0] mc_plain_mask = 8'h13;

  assign pready_o = ce_i;
  assign pslverr_o = psel_i && penable_i && !hit_any;
  assign prdata_o = prdata_reg;

  // Turn-off sequence
  logic off_bit;
  logic off_window;
  logic off_active;
  monitor_off_seq u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_i(wr_mc),
    .off_i(pwdata_i[sleep_pkg::MC_OFF]),
    .unlock_i(pwdata_i[sleep_pkg::MC_UNLOCK]),
    .off_bit_o(off_bit),
    .window_o(off_window),
    .active_o(off_active)
  );

  // Power state machine
  sleep_pkg::power_state_e state_reg;
  sleep_pkg::power_state_e state_next;
  mode_t mode_reg;
  mode_t mode_next;
  logic mon_off_reg;
  logic mon_off_next;
  logic timer_load;
  logic [15:0] timer_val;
  logic timer_done;
  wire arm = sc_reg[sleep_pkg::SC_ARM];
  wire [2:0] mode_field = sc_reg[sleep_pkg::SC_MODE +: sleep_pkg::MODE_W];
  wire mode_res = mode_field == sleep_pkg::MODE_RES4 ||
                  mode_field == sleep_pkg::MODE_RES5;
  wire go_sleep = sleep_instr_i && arm && !mode_res;
  wire [2:0] sel_mode = effective_mode(mode_field, ext_crystal_i);

  wake_timer #(
    .W(sleep_pkg::CNT_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(timer_load),
    .load_val_i(timer_val),
    .done_o(timer_done)
  );

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    mon_off_next = mon_off_reg;
    timer_load = 1'b0;
    timer_val = sleep_pkg::HALT_CYC;
    case (state_reg)
      sleep_pkg::ST_ACTIVE: begin
        if (go_sleep) begin
          state_next = sleep_pkg::ST_SLEEP;
          mode_next = mode_t'(sel_mode);
          mon_off_next = off_active && is_deep(mode_t'(sel_mode));
        end
      end
      sleep_pkg::ST_SLEEP: begin
        if (wake_i) begin
          state_next = sleep_pkg::ST_WAKE;
          mon_off_next = 1'b0;
          timer_load = 1'b1;
          timer_val = wake_cycles(mode_reg);
        end
      end
      sleep_pkg::ST_WAKE: begin
        if (timer_done) begin
          state_next = sleep_pkg::ST_HALT;
          timer_load = 1'b1;
          timer_val = sleep_pkg::HALT_CYC;
        end
      end
      sleep_pkg::ST_HALT: begin
        if (timer_done) begin
          state_next = sleep_pkg::ST_ACTIVE;
        end
      end
      default: begin
        state_next = sleep_pkg::ST_ACTIVE;
      end
    endcase
  end

  // Clock and analog control, aligned with the next state
  sleep_pkg::clk_en_s clk_reg;
  sleep_pkg::clk_en_s clk_next;
  sleep_pkg::analog_ctl_s ana_reg;
  sleep_pkg::analog_ctl_s ana_next;
  logic [7:0] periph_reg;
  logic [7:0] periph_next;
  logic [NPIN-1:0] inbuf_reg;
  logic [NPIN-1:0] inbuf_next;
  logic adc_prev_reg;
  logic adc_ext_reg;
  wire slp_n = state_next == sleep_pkg::ST_SLEEP ||
               state_next == sleep_pkg::ST_WAKE;
  wire deep_n = slp_n && is_deep(mode_next);
  wire idle_n = mode_next == sleep_pkg::MODE_IDLE;
  wire stop_all_n = mode_next == sleep_pkg::MODE_PDOWN ||
                    mode_next == sleep_pkg::MODE_STANDBY;
  wire osc_stop_n = mode_next == sleep_pkg::MODE_PDOWN ||
                    mode_next == sleep_pkg::MODE_PSAVE;
  wire adc_ext_set = adc_prev_reg && !adc_enable_i;
  wire adc_ext_clr = adc_conv_start_i && adc_enable_i;
  wire mon_on_n = monitor_fuse_en_i && !mon_off_next;

  assign clk_next.cpu = state_next == sleep_pkg::ST_ACTIVE;
  assign clk_next.io = !slp_n || idle_n;
  assign clk_next.adc = !deep_n;
  assign clk_next.async_timer = !(slp_n && stop_all_n);
  assign clk_next.main_osc = !(slp_n && osc_stop_n) ||
                             debug_enable_fuse_i;
  assign ana_next.adc_on = adc_enable_i;
  assign ana_next.adc_extended = adc_ext_set || (adc_ext_reg && !adc_ext_clr);
  assign ana_next.comp_on = comp_enable_i && !deep_n;
  assign ana_next.vref_on = mon_on_n || adc_enable_i ||
                            (comp_enable_i && comp_use_ref_i);
  assign ana_next.monitor_on = mon_on_n;
  assign ana_next.wdt_run = wdt_enable_i;
  // Gated peripherals hold their state because their clock just stops
  assign periph_next = {{7{clk_next.io}}, clk_next.adc} &
                       ~gate_reg & sleep_pkg::GATE_MASK;
  assign inbuf_next = deep_n ? wake_pin_need_i : {NPIN{1'b1}};

  assign clk_en_o = clk_reg;
  assign analog_o = ana_reg;
  assign periph_clk_en_o = periph_reg;
  assign periph_access_o = ~gate_reg & sleep_pkg::GATE_MASK;
  assign input_buf_en_o = inbuf_reg;
  assign pullup_global_off_o = mc_reg[sleep_pkg::MC_PUD];
  assign vector_table_select_o = mc_reg[sleep_pkg::MC_VSEL];

  // Read word
  wire [7:0] sc_rd = {4'h0, sc_reg[sleep_pkg::SC_W-1:0]};
  wire [7:0] mc_rd = {1'b0, off_bit, off_window, mc_reg[4:0]};
  wire [7:0] st_rd = {1'b0, adc_ext_reg, mon_off_reg, mode_reg, state_reg};
  wire [7:0] rd_byte = hit_sc ? sc_rd :
                       hit_mc ? mc_rd :
                       hit_gate ? gate_reg :
                       hit_st ? st_rd : 8'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sc_reg <= sleep_pkg::SC_RESET;
      mc_reg <= sleep_pkg::MC_RESET;
      gate_reg <= sleep_pkg::GATE_RESET;
      prdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_sc) begin
        sc_reg <= {4'h0, pwdata_i[sleep_pkg::SC_W-1:0]};
      end
      if (wr_mc) begin
        mc_reg <= pwdata_i[7:0] & mc_plain_mask;
      end
      if (wr_gate) begin
        gate_reg <= pwdata_i[7:0] & sleep_pkg::GATE_MASK;
      end
      if (setup_ph) begin
        prdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= sleep_pkg::ST_ACTIVE;
      mode_reg <= sleep_pkg::MODE_IDLE;
      mon_off_reg <= 1'b0;
      adc_prev_reg <= 1'b0;
      adc_ext_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      mon_off_reg <= mon_off_next;
      adc_prev_reg <= adc_enable_i;
      adc_ext_reg <= ana_next.adc_extended;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_reg <= '1;
      ana_reg <= '0;
      periph_reg <= sleep_pkg::GATE_MASK;
      inbuf_reg <= '1;
    end else if (ce_i) begin
      clk_reg <= clk_next;
      ana_reg <= ana_next;
      periph_reg <= periph_next;
      inbuf_reg <= inbuf_next;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);

  wire in_sleep = state_reg == sleep_pkg::ST_SLEEP;
  wire halt_st = state_reg == sleep_pkg::ST_HALT;
  wire wake_st = state_reg == sleep_pkg::ST_WAKE;

  sequence s_wake_six;
    wake_st [*6] ##1 halt_st;
  endsequence
  sequence s_halt_four;
    halt_st [*4] ##1 state_reg == sleep_pkg::ST_ACTIVE;
  endsequence

  property p_arm;
    state_reg == sleep_pkg::ST_ACTIVE && sleep_instr_i && !arm
      |=> state_reg == sleep_pkg::ST_ACTIVE && clk_en_o.cpu;
  endproperty
  a_arm: assert property (p_arm)
    else $error("sleep entered without arm bit");

  property p_reserved;
    state_reg == sleep_pkg::ST_ACTIVE && sleep_instr_i && mode_res
      |=> state_reg == sleep_pkg::ST_ACTIVE;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved mode put core to sleep");

  property p_standby_wake;
    in_sleep && wake_i && mode_reg == sleep_pkg::MODE_STANDBY
      |=> s_wake_six;
  endproperty
  a_standby_wake: assert property (p_standby_wake)
    else $error("standby wake not six cycles");

  property p_ext_standby_wake;
    in_sleep && wake_i && mode_reg == sleep_pkg::MODE_EXT_STANDBY
      |=> s_wake_six;
  endproperty
  a_ext_standby_wake: assert property (p_ext_standby_wake)
    else $error("extended standby wake not six cycles");

  property p_halt;
    wake_st && timer_done |=> s_halt_four;
  endproperty
  a_halt: assert property (p_halt)
    else $error("core halt after wake not four cycles");

  property p_gate;
    $past(gate_reg) != 8'h00
      |-> (periph_clk_en_o & $past(gate_reg)) == 8'h00;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated peripheral clock still running");

  property p_deep;
    in_sleep && is_deep(mode_reg)
      |-> !analog_o.comp_on && periph_clk_en_o == 8'h00;
  endproperty
  a_deep: assert property (p_deep)
    else $error("clocks or comparator running in deep sleep");

  property p_monitor;
    monitor_fuse_en_i && !(in_sleep && mon_off_reg)
      |=> analog_o.monitor_on || (in_sleep && mon_off_reg);
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("supply monitor dropped");

  property p_vref;
    adc_enable_i || (comp_enable_i && comp_use_ref_i) |=> analog_o.vref_on;
  endproperty
  a_vref: assert property (p_vref)
    else $error("reference off while needed");

  property p_pdown;
    in_sleep && mode_reg == sleep_pkg::MODE_PDOWN && !debug_enable_fuse_i
      |-> !clk_en_o.main_osc && !clk_en_o.async_timer && !clk_en_o.io;
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("clock running in power-down");

  property p_standby_osc;
    in_sleep && mode_reg == sleep_pkg::MODE_STANDBY |-> clk_en_o.main_osc;
  endproperty
  a_standby_osc: assert property (p_standby_osc)
    else $error("oscillator stopped in standby");

  property p_inbuf;
    in_sleep && is_deep(mode_reg) |-> input_buf_en_o == $past(wake_pin_need_i);
  endproperty
  a_inbuf: assert property (p_inbuf)
    else $error("input buffers on in deep sleep");
endmodule
`default_nettype wire

// ==== bench/sleep_mode_power_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_power_control_test;
  localparam logic [11:0] A_SC = {sleep_pkg::IDX_SLEEP, 2'h0};
  localparam logic [11:0] A_MC = {sleep_pkg::IDX_MCU, 2'h0};
  localparam logic [11:0] A_GT = {sleep_pkg::IDX_GATE, 2'h0};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, perr, err, pullup_global_off, vsel;
  logic sleep_in = 1'h0;
  logic wake = 1'h0;
  logic xtal = 1'h1;
  logic dbg = 1'h0;
  logic mfuse = 1'h1;
  logic adc_en = 1'h1;
  logic adc_go = 1'h0;
  logic cmp_en = 1'h1;
  logic cmp_ref = 1'h0;
  logic wdt = 1'h1;
  logic [22:0] need = 23'h2A5A5A;
  logic [22:0] ibuf;
  logic [7:0] pclk, pacc;
  sleep_pkg::clk_en_s ck;
  sleep_pkg::analog_ctl_s an;
  logic [2:0] md [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [4:0] cke [5] = '{5'h0D, 5'h00, 5'h00, 5'h01, 5'h01};
  int wt [5] = '{6, 7, 7, 11, 11};
  logic [7:0] bad [3] = '{8'h04, 8'h09, 8'h0B};
  int mismatches = 0;
  int check_count = 0;
  int n;

  sleep_mode_power_control #(.START_UP_CYC(16'h0002)) u_dut (
    .clk_i(clk), .rst_i(rst), .ce_i(1'h1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .sleep_instr_i(sleep_in), .wake_i(wake),
    .ext_crystal_i(xtal), .debug_enable_fuse_i(dbg),
    .monitor_fuse_en_i(mfuse), .adc_enable_i(adc_en),
    .adc_conv_start_i(adc_go), .comp_enable_i(cmp_en),
    .comp_use_ref_i(cmp_ref), .wdt_enable_i(wdt),
    .wake_pin_need_i(need), .clk_en_o(ck), .periph_clk_en_o(pclk),
    .periph_access_o(pacc), .analog_o(an), .input_buf_en_o(ibuf),
    .pullup_global_off_o(pullup_global_off), .vector_table_select_o(vsel)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One APB transfer; psel stays high for a back-to-back follower
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    err = perr;
    penable <= 1'h0;
  endtask

  task automatic idle();
    psel <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
    idle();
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    idle();
    chk(rd, {24'h0, e});
  endtask

  task automatic slp();
    sleep_in <= 1'h1;
    @(posedge clk);
    sleep_in <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  // Counts edges from the wake edge until the core clock returns
  task automatic wk(input int e);
    wake <= 1'h1;
    @(posedge clk);
    wake <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ck.cpu !== 1'h1 && n < 100);
    chk(n, e);
    if (n >= 100) begin
      final_report();
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rdc(A_SC, 8'h00);
    rdc(A_MC, 8'h00);
    rdc(A_GT, 8'h00);
    wr(A_SC, 8'hFF);
    rdc(A_SC, 8'h0F);
    apb(1'h0, 12'h004, 8'h00);
    idle();
    chk(rd, 32'h0);
    chk(err, 1'h1);
    // Peripheral gating
    wr(A_GT, 8'h01);
    @(posedge clk);
    chk(pclk, 8'hEE);
    chk(pacc, 8'hEE);
    wr(A_GT, 8'hFF);
    rdc(A_GT, 8'hEF);
    chk(pclk, 8'h00);
    wr(A_GT, 8'h00);
    @(posedge clk);
    chk(pclk, 8'hEF);
    // Sleep refused when not armed or mode reserved
    for (int i = 0; i < 3; i++) begin
      wr(A_SC, bad[i]);
      slp();
      chk(ck.cpu, 1'h1);
    end
    // Every sleep mode except noise reduction, entry and wake
    for (int i = 0; i < 5; i++) begin
      wr(A_SC, {4'h0, md[i], 1'h1});
      slp();
      chk(ck & 5'h1D, cke[i]);
      chk(an.wdt_run, 1'h1);
      chk(an.monitor_on, 1'h1);
      chk(an.adc_on, 1'h1);
      chk(an.comp_on, md[i] < 3'h2);
      chk(an.vref_on, 1'h1);
      chk(pclk, md[i] == 3'h0 ? 8'hEF : 8'h00);
      chk(ibuf, md[i] == 3'h0 ? 23'h7FFFFF : need);
      wk(wt[i]);
    end
    dbg <= 1'h1;
    wr(A_SC, 8'h05);
    slp();
    chk(ck.main_osc, 1'h1);
    wk(7);
    dbg <= 1'h0;
    xtal <= 1'h0;
    wr(A_SC, 8'h0D);
    slp();
    chk(ck.main_osc, 1'h0);
    wk(7);
    xtal <= 1'h1;
    wr(A_MC, 8'h12);
    rdc(A_MC, 8'h12);
    chk({pullup_global_off, vsel}, 2'h3);
    // Supply monitor turn-off sequence
    wr(A_MC, 8'h40);
    rdc(A_MC, 8'h00);
    apb(1'h1, A_MC, 8'h60);
    apb(1'h1, A_MC, 8'h40);
    apb(1'h0, A_MC, 8'h00);
    idle();
    chk(rd[6], 1'h1);
    repeat (8) @(posedge clk);
    rdc(A_MC, 8'h00);
    wr(A_SC, 8'h05);
    apb(1'h1, A_MC, 8'h60);
    apb(1'h1, A_MC, 8'h40);
    idle();
    repeat (3) @(posedge clk);
    slp();
    chk(an.monitor_on, 1'h0);
    wk(7);
    chk(an.monitor_on, 1'h1);
    wr(A_SC, 8'h04);
    slp();
    chk(ck.cpu, 1'h1);
    // Converter restart and reference demand
    adc_en <= 1'h0;
    repeat (3) @(posedge clk);
    adc_en <= 1'h1;
    repeat (3) @(posedge clk);
    chk(an.adc_extended, 1'h1);
    adc_go <= 1'h1;
    @(posedge clk);
    adc_go <= 1'h0;
    repeat (3) @(posedge clk);
    chk(an.adc_extended, 1'h0);
    adc_en <= 1'h0;
    cmp_en <= 1'h0;
    mfuse <= 1'h0;
    repeat (3) @(posedge clk);
    chk(an.vref_on, 1'h0);
    cmp_en <= 1'h1;
    cmp_ref <= 1'h1;
    wr(A_SC, 8'h05);
    slp();
    chk(an.comp_on, 1'h0);
    chk(an.vref_on, 1'h1);
    wk(7);
    final_report();
  end
endmodule
`default_nettype wire
